//--- dv/dssr_asserts.sv
// Concurrent checks on the serial link between the converter end and the host end.
`timescale 1ns/1ps
module dssr_asserts (
   input wire logic clock,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic dout_o,
   input wire logic dout_oe,
   input wire logic dout
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   logic sclk_r;
   logic [5:0] fall_r;
   always_ff @(posedge clock) begin
      sclk_r <= sclk;
   end
   // Falls of the frame counted 1 to 32, so a sampled bit has a known position.
   always_ff @(posedge clock) begin
      if (rst || cs_n) begin
         fall_r <= 6'h00;
      end else if (sclk_r && !sclk) begin
         fall_r <= (fall_r == 6'h20) ? 6'h01 : fall_r + 6'h01;
      end
   end
   a_oe_released: assert property (cs_n [*5] |-> !dout_oe)
      else $error("data line driven while deselected");
   a_oe_driven: assert property (!cs_n [*5] |-> dout_oe)
      else $error("data line not driven while selected");
   a_idle_clk_high: assert property (cs_n |-> sclk)
      else $error("serial clock low outside a frame");
   a_sel_fall_clk: assert property ($fell(cs_n) |-> sclk && $stable(sclk))
      else $error("select fell with serial clock low or rising");
   a_low_half: assert property ($fell(sclk) |-> !sclk [*3] ##1 sclk)
      else $error("serial clock low time wrong");
   a_high_half: assert property ($rose(sclk) && !cs_n |-> sclk [*3])
      else $error("serial clock high time too short");
   a_sel_gap: assert property ($rose(cs_n) |-> cs_n [*5])
      else $error("select high gap too short");
   a_frame_whole: assert property ($rose(cs_n) && !$past(rst) |-> fall_r == 6'h20)
      else $error("frame ended off a conversion boundary");
   a_gap_zeros: assert property ($fell(sclk) && (fall_r inside {[6'h01:6'h04], [6'h11:6'h14]})
      |-> dout_oe && !dout)
      else $error("padding bit not zero");
   a_bit_holds: assert property ($fell(sclk) |-> $stable(dout_o) [*2])
      else $error("data bit changed right at a fall");
   c_frame_end: cover property ($rose(cs_n) && fall_r == 6'h20);
   c_one_bit: cover property (dout_oe && dout_o);
   c_stall: cover property (!cs_n && sclk [*8]);
endmodule

//--- dv/tb_dual_sample_serial_readout.sv
// Self-checking bench joining the converter end and the host end.
`timescale 1ns/1ps
module tb_dual_sample_serial_readout;
   import dssr_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic start = 1'b0;
   logic rd_ready = 1'b0;
   logic [3:0] conv_count = 4'h0;
   logic [RES_W-1:0] ch_a = 12'h000;
   logic [RES_W-1:0] ch_b = 12'h000;
   logic busy, rd_valid, abort_pulse, sample_pulse, abort2, sample2;
   logic seen_s = 1'b0;
   logic seen_a = 1'b0;
   logic [WORD_W-1:0] rd_data;
   logic [RES_W-1:0] va [4] = '{12'h7ff, 12'h000, 12'h001, 12'ha5c};
   logic [RES_W-1:0] vb [4] = '{12'h800, 12'hfff, 12'h5a3, 12'h3c1};
   dssr_phase_t phase, phase2;
   int n_mismatch = 0;
   int cmp_count = 0;
   dssr_link_if dssr_link_if_i ();
   dssr_link_if dssr_link_if2_i ();
   dssr_device dssr_device_i (.clock(clock), .rst(rst), .ce(ce), .link(dssr_link_if_i),
      .ch_a(ch_a), .ch_b(ch_b), .phase(phase), .sample_pulse(sample_pulse),
      .abort_pulse(abort_pulse));
   dssr_host dssr_host_i (.clock(clock), .rst(rst), .ce(ce), .link(dssr_link_if_i),
      .start(start), .conv_count(conv_count), .busy(busy), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_data(rd_data));
   // A second converter end faced by the bench, which can break off a frame early.
   dssr_device dssr_device2_i (.clock(clock), .rst(rst), .ce(ce), .link(dssr_link_if2_i),
      .ch_a(ch_a), .ch_b(ch_b), .phase(phase2), .sample_pulse(sample2),
      .abort_pulse(abort2));
   dssr_asserts dssr_asserts_i (.clock(clock), .rst(rst), .cs_n(dssr_link_if_i.cs_n),
      .sclk(dssr_link_if_i.sclk), .dout_o(dssr_link_if_i.dout_o),
      .dout_oe(dssr_link_if_i.dout_oe), .dout(dssr_link_if_i.dout));
   initial begin
      dssr_link_if2_i.cs_n = 1'b1;
      dssr_link_if2_i.sclk = 1'b1;
      forever #10 clock = ~clock;
   end
   always @(posedge clock) begin
      if (sample2 === 1'b1) seen_s <= 1'b1;
      if (abort2 === 1'b1) seen_a <= 1'b1;
   end
   task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic go(input logic [3:0] n, input logic exp_busy);
      @(posedge clock);
      conv_count <= n;
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      @(negedge clock);
      chk(busy, exp_busy);
   endtask
   task automatic wait_idle();
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 8000) begin
         @(negedge clock);
         k++;
      end
      chk(busy, 1'b0);
   endtask
   // Ready is held from the edge after entry until the edge that pops the word.
   task automatic rd(input logic [WORD_W-1:0] exp);
      int k;
      k = 0;
      @(posedge clock);
      rd_ready <= 1'b1;
      @(negedge clock);
      while (rd_valid !== 1'b1 && k < 8000) begin
         @(negedge clock);
         k++;
      end
      // A word that never arrives counts as a mismatch of its own.
      chk(rd_valid, 1'b1);
      chk(rd_data, exp);
      @(posedge clock);
      rd_ready <= 1'b0;
   endtask
   task automatic set_ch(input logic [RES_W-1:0] a, input logic [RES_W-1:0] b);
      @(posedge clock);
      ch_a <= a;
      ch_b <= b;
   endtask
   initial begin
      repeat (40000) @(posedge clock);
      n_mismatch++;
      $display("[ERR] %0t run did not finish in time", $time);
      tally_and_finish();
   end
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         set_ch(va[i], vb[i]);
         go(4'h0, 1'b1);
         wait_idle();
         rd({va[i], vb[i]});
         chk(phase, DSSR_PD);
      end
      $display("single conversion codes done");
      set_ch(12'h123, 12'hedc);
      go(4'h4, 1'b1);
      wait_idle();
      for (int i = 0; i < 4; i++) rd({12'h123, 12'hedc});
      $display("continuous conversions done");
      set_ch(12'h0f0, 12'h70f);
      go(4'h0, 1'b1);
      wait_idle();
      go(4'h0, 1'b1);
      wait_idle();
      set_ch(12'h801, 12'h7fe);
      go(4'hf, 1'b1);
      // Two words already wait, so the fifteenth conversion meets a full buffer and stalls.
      repeat (3600) @(negedge clock);
      chk(busy, 1'b1);
      chk({dssr_link_if_i.cs_n, dssr_link_if_i.sclk}, 2'b01);
      rd({12'h0f0, 12'h70f});
      wait_idle();
      go(4'h0, 1'b0);
      rd({12'h0f0, 12'h70f});
      for (int i = 0; i < 15; i++) rd({12'h801, 12'h7fe});
      @(negedge clock);
      chk(rd_valid, 1'b0);
      $display("buffer fill and stall done");
      go(4'h0, 1'b1);
      repeat (40) @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      chk({dssr_link_if_i.cs_n, dssr_link_if_i.dout_oe, busy, rd_valid}, 4'h8);
      chk(phase, DSSR_PD);
      $display("reset mid-frame done");
      @(posedge clock);
      dssr_link_if2_i.sclk <= 1'b0;
      repeat (3) @(posedge clock);
      dssr_link_if2_i.cs_n <= 1'b0;
      for (int t = 0; t < 7; t++) begin
         repeat (3) @(posedge clock);
         dssr_link_if2_i.sclk <= ~dssr_link_if2_i.sclk;
      end
      repeat (8) @(negedge clock);
      chk({seen_s, seen_a, dssr_link_if2_i.dout_oe}, 3'h5);
      chk(phase2, DSSR_CONV);
      @(posedge clock);
      dssr_link_if2_i.cs_n <= 1'b1;
      repeat (8) @(negedge clock);
      chk({seen_a, dssr_link_if2_i.dout_oe}, 2'h2);
      chk(phase2, DSSR_PD);
      $display("early abort done");
      tally_and_finish();
   end
endmodule

//--- hw/dssr_device.sv
// Converter end: conversion sequencing and serial result output.
//
// Operation
// - Chip select fall starts, rise ends frame.
// - Output floats while chip select is high.
// - First three clocks track both inputs.
// - Next twelve clocks convert and shift bits.
// - Falls 1-4 zeros, 5-16 channel A.
// - Falls 17-20 zeros, 21-32 channel B.
// - Continuous conversions of 32 clocks each.
// - Clock level at select fall picks entry.
// - Acquire, convert, power down; high means down.
// - Host sets sample rate by select rate.
// - Host keeps serial clock in allowed range.
// - Select never falls with a clock rise.
// - Results are 12-bit two's complement codes.
// - Bits change on falls, host samples later.
// - Early select rise aborts and floats output.
`timescale 1ns/1ps
module dssr_device (
   input logic clock,
   input logic rst,
   input logic ce,
   dssr_link_if.dev link,
   input logic [dssr_pkg::RES_W-1:0] ch_a,
   input logic [dssr_pkg::RES_W-1:0] ch_b,
   output dssr_pkg::dssr_phase_t phase,
   output logic sample_pulse,
   output logic abort_pulse
);
   import dssr_pkg::*;

   // Link pins arrive from another party, so each passes two flip-flops.
   // The third stage only remembers the previous level for edge detection.
   logic sclk_s1_r;
   logic sclk_s2_r;
   logic sclk_s3_r;
   logic cs_s1_r;
   logic cs_s2_r;
   logic cs_s3_r;

   logic started_r;
   logic [4:0] pos_r;
   logic [4:0] pos_nxt;
   logic [RES_W-1:0] hold_a_r;
   logic [RES_W-1:0] hold_b_r;
   dssr_phase_t phase_r;
   dssr_phase_t phase_nxt;
   logic dout_r;
   logic dout_nxt;
   logic oe_r;
   logic sample_r;
   logic abort_r;

   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   logic fall_evt;

   always_ff @(posedge clock) begin
      if (rst) begin
         sclk_s1_r <= 1'b1;
         sclk_s2_r <= 1'b1;
         sclk_s3_r <= 1'b1;
      end else if (ce) begin
         sclk_s1_r <= link.sclk;
         sclk_s2_r <= sclk_s1_r;
         sclk_s3_r <= sclk_s2_r;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
         cs_s3_r <= 1'b1;
      end else if (ce) begin
         cs_s1_r <= link.cs_n;
         cs_s2_r <= cs_s1_r;
         cs_s3_r <= cs_s2_r;
      end
   end

   assign sclk_fall = sclk_s3_r & ~sclk_s2_r;
   assign cs_fall = cs_s3_r & ~cs_s2_r;
   assign cs_rise = ~cs_s3_r & cs_s2_r;

   // With the clock high at the select fall, the next clock fall is the first
   // one; with it low, or falling together, the select fall counts as the
   // first clock fall itself.
   always_comb begin
      if (cs_fall) begin
         fall_evt = ~sclk_s2_r;
      end else begin
         fall_evt = sclk_fall & ~cs_s2_r;
      end
   end

   // The 5-bit position wraps by itself, which restarts acquisition on the
   // fall after every 32nd rising edge.
   always_comb begin
      if (started_r) begin
         pos_nxt = pos_r + 5'h1;
      end else begin
         pos_nxt = POS_FIRST;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         started_r <= 1'b0;
         pos_r <= POS_FIRST;
      end else if (ce) begin
         if (cs_s2_r) begin
            started_r <= 1'b0;
            pos_r <= POS_FIRST;
         end else if (fall_evt) begin
            started_r <= 1'b1;
            pos_r <= pos_nxt;
         end
      end
   end

   always_comb begin
      if (pos_nxt < POS_CONV) begin
         phase_nxt = DSSR_ACQ;
      end else if (pos_nxt < POS_PD) begin
         phase_nxt = DSSR_CONV;
      end else begin
         phase_nxt = DSSR_PD;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         phase_r <= DSSR_PD;
      end else if (ce) begin
         if (cs_s2_r) begin
            phase_r <= DSSR_PD;
         end else if (fall_evt) begin
            phase_r <= phase_nxt;
         end
      end
   end

   // Both channels are frozen on the same edge, so the pair keeps its
   // relative phase; the codes pass through unchanged as two's complement.
   always_ff @(posedge clock) begin
      if (rst) begin
         hold_a_r <= '0;
         hold_b_r <= '0;
         sample_r <= 1'b0;
      end else if (ce) begin
         sample_r <= 1'b0;
         if (~cs_s2_r && fall_evt && pos_nxt == POS_CONV) begin
            hold_a_r <= ch_a;
            hold_b_r <= ch_b;
            sample_r <= 1'b1;
         end
      end
   end

   // Serial bit for the edge being taken.
   always_comb begin
      logic [4:0] idx_a;
      logic [4:0] idx_b;
      idx_a = POS_A_LSB - pos_nxt;
      idx_b = POS_B_LSB - pos_nxt;
      if (pos_nxt >= POS_A_MSB && pos_nxt <= POS_A_LSB) begin
         dout_nxt = hold_a_r[idx_a[3:0]];
      end else if (pos_nxt >= POS_B_MSB) begin
         dout_nxt = hold_b_r[idx_b[3:0]];
      end else begin
         dout_nxt = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         dout_r <= 1'b0;
      end else if (ce) begin
         if (cs_s2_r) begin
            dout_r <= 1'b0;
         end else if (fall_evt) begin
            dout_r <= dout_nxt;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         oe_r <= 1'b0;
      end else if (ce) begin
         oe_r <= ~cs_s2_r;
      end
   end

   // A rise before the sixteenth fall of the running conversion loses it.
   always_ff @(posedge clock) begin
      if (rst) begin
         abort_r <= 1'b0;
      end else if (ce) begin
         abort_r <= cs_rise & (~started_r | (pos_r < POS_PD));
      end
   end

   assign link.dout_o = dout_r;
   assign link.dout_oe = oe_r;
   assign phase = phase_r;
   assign sample_pulse = sample_r;
   assign abort_pulse = abort_r;

endmodule

//--- hw/dssr_host.sv
// Host end: frame generation, result capture and the result FIFO.
`timescale 1ns/1ps
module dssr_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input logic clock,
   input logic rst,
   input logic ce,
   input logic in_valid,
   output logic in_ready,
   input logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   // Pointers wrap naturally, so DEPTH must be a power of two.
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready = cnt_r != (AW + 1)'(DEPTH);
   assign out_valid = cnt_r != '0;
   assign out_data = mem_r[rd_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clock) begin
      if (ce && push) begin
         mem_r[wr_r] <= in_data;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else if (ce) begin
         if (push) begin
            wr_r <= wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= rd_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule

module dssr_host (
   input logic clock,
   input logic rst,
   input logic ce,
   dssr_link_if.host link,
   input logic start,
   input logic [3:0] conv_count,
   output logic busy,
   output logic rd_valid,
   input logic rd_ready,
   output logic [dssr_pkg::WORD_W-1:0] rd_data
);
   import dssr_pkg::*;

   dssr_host_state_t state_r;
   logic [1:0] div_r;
   logic sclk_r;
   logic cs_n_r;
   logic busy_r;
   logic [5:0] falls_r;
   logic [3:0] left_r;
   logic [2:0] gap_r;
   logic [FRAME_W-1:0] shift_r;
   logic [FRAME_W-1:0] frame;
   logic [WORD_W-1:0] word_r;
   logic push_r;
   logic din_s1_r;
   logic din_s2_r;
   logic in_ready;
   logic tick;
   logic fall_point;
   logic conv_end;
   logic push_go;

   always_ff @(posedge clock) begin
      if (rst) begin
         din_s1_r <= 1'b0;
         din_s2_r <= 1'b0;
      end else if (ce) begin
         din_s1_r <= link.dout;
         din_s2_r <= din_s1_r;
      end
   end

   assign tick = (state_r == H_RUN) && (div_r == DIV_LAST);
   // Each bit is taken just before the following fall; the round trip
   // through both synchronisers is too long to meet the rising edge.
   assign fall_point = tick & sclk_r;
   assign conv_end = fall_point && (falls_r == FALLS_PER_CONV);
   assign frame = (state_r == H_WAIT) ? shift_r : {shift_r[FRAME_W-2:0], din_s2_r};
   assign push_go = (conv_end || state_r == H_WAIT) && in_ready;

   always_ff @(posedge clock) begin
      if (rst) begin
         div_r <= 2'h0;
      end else if (ce) begin
         if (state_r != H_RUN || tick) begin
            div_r <= 2'h0;
         end else begin
            div_r <= div_r + 2'h1;
         end
      end
   end

   // A full FIFO stalls the serial clock high until a slot frees up.
   always_ff @(posedge clock) begin
      if (rst) begin
         state_r <= H_IDLE;
         sclk_r <= 1'b1;
         cs_n_r <= 1'b1;
         busy_r <= 1'b0;
         falls_r <= 6'h00;
         left_r <= 4'h0;
         gap_r <= 3'h0;
      end else if (ce) begin
         case (state_r)
            H_IDLE: begin
               sclk_r <= 1'b1;
               if (start && in_ready) begin
                  cs_n_r <= 1'b0;
                  busy_r <= 1'b1;
                  falls_r <= 6'h00;
                  left_r <= (conv_count == 4'h0) ? 4'h1 : conv_count;
                  state_r <= H_RUN;
               end
            end
            H_RUN: begin
               if (tick && !sclk_r) begin
                  sclk_r <= 1'b1;
               end else if (conv_end && !in_ready) begin
                  state_r <= H_WAIT;
               end else if (fall_point && !conv_end) begin
                  sclk_r <= 1'b0;
                  falls_r <= falls_r + 6'h01;
               end
            end
            H_WAIT: begin
            end
            H_GAP: begin
               gap_r <= gap_r + 3'h1;
               if (gap_r == GAP_LAST) begin
                  busy_r <= 1'b0;
                  state_r <= H_IDLE;
               end
            end
            default: begin
               state_r <= H_IDLE;
            end
         endcase
         if (push_go) begin
            if (left_r == 4'h1) begin
               cs_n_r <= 1'b1;
               gap_r <= 3'h0;
               state_r <= H_GAP;
            end else begin
               left_r <= left_r - 4'h1;
               sclk_r <= 1'b0;
               falls_r <= 6'h01;
               state_r <= H_RUN;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         shift_r <= 32'h0000_0000;
      end else if (ce && fall_point && falls_r != 6'h00) begin
         shift_r <= frame;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         push_r <= 1'b0;
         word_r <= '0;
      end else if (ce) begin
         push_r <= push_go;
         if (push_go) begin
            word_r <= {frame[FRAME_A_LSB +: RES_W], frame[FRAME_B_LSB +: RES_W]};
         end
      end
   end

   dssr_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .in_valid(push_r),
      .in_ready(in_ready),
      .in_data(word_r),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data)
   );

   assign link.cs_n = cs_n_r;
   assign link.sclk = sclk_r;
   assign busy = busy_r;

endmodule

//--- hw/dssr_link_if.sv
// Serial link between the converter end and the host end.
`timescale 1ns/1ps
interface dssr_link_if;
   logic cs_n;
   logic sclk;
   logic dout_o;
   logic dout_oe;
   logic dout;

   // A floating data line reads as low at the host.
   assign dout = dout_oe & dout_o;

   modport dev (
      input cs_n,
      input sclk,
      output dout_o,
      output dout_oe
   );

   modport host (
      output cs_n,
      output sclk,
      input dout
   );
endinterface

//--- hw/dssr_pkg.sv
// Shared constants and types for the dual-channel serial readout link.
package dssr_pkg;

   // System clock of both ends.
   localparam int CLK_HZ = 50_000_000;

   // Allowed serial clock range and the rate the host end aims for.
   localparam int SCLK_MIN_HZ = 6_400_000;
   localparam int SCLK_MAX_HZ = 16_000_000;
   localparam int SCLK_TGT_HZ = 8_000_000;

   // Half period of the serial clock in system cycles, rounded down so the
   // rate never falls below the target (3 cycles gives 8.33 MHz).
   localparam int SCLK_HALF_CYC = CLK_HZ / (2 * SCLK_TGT_HZ);
   localparam logic [1:0] DIV_LAST = 2'(SCLK_HALF_CYC - 1);

   // Least time chip select stays high between frames, rounded up.
   localparam int CS_HIGH_NS = 100;
   localparam int CS_HIGH_CYC = (CS_HIGH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [2:0] GAP_LAST = 3'(CS_HIGH_CYC - 1);

   // Result width and packing of one conversion into a FIFO word.
   localparam int RES_W = 12;
   localparam int WORD_W = 2 * RES_W;
   localparam int FRAME_W = 32;
   localparam int FRAME_A_LSB = 16;
   localparam int FRAME_B_LSB = 0;
   localparam int FIFO_DEPTH = 16;

   // Falling edges per conversion and edge positions (position = edge - 1).
   localparam logic [5:0] FALLS_PER_CONV = 6'h20;
   localparam logic [4:0] POS_FIRST = 5'h0;
   localparam logic [4:0] POS_CONV = 5'h3;
   localparam logic [4:0] POS_A_MSB = 5'h4;
   localparam logic [4:0] POS_A_LSB = 5'hF;
   localparam logic [4:0] POS_PD = 5'hF;
   localparam logic [4:0] POS_B_MSB = 5'h14;
   localparam logic [4:0] POS_B_LSB = 5'h1F;

   typedef enum logic [1:0] {
      DSSR_PD,
      DSSR_ACQ,
      DSSR_CONV
   } dssr_phase_t;

   typedef enum logic [1:0] {
      H_IDLE,
      H_RUN,
      H_WAIT,
      H_GAP
   } dssr_host_state_t;

endpackage
